// ### design/cdl_exec.sv
// Divide, BCD adjust, interrupt hold, hardware loop and distance slice
// Functional notes
// - BCD adjust corrects working register low byte, changes only carry, one cycle
// - Interrupt hold blocks interrupts for literal count cycles, no flag change
// - Signed 16/16 divide takes 18 cycles, sets N, Z, C, OV
// - Signed 32/16 divide takes 18 cycles, sets N, Z, C, OV
// - Unsigned 16/16 divide takes 18 cycles, sets N, Z, C, OV
// - Unsigned 32/16 divide takes 18 cycles, sets N, Z, C, OV
// - Fractional divide takes 18 cycles, only on DSP variants
// - Literal loop repeats to PC plus offset literal+1 times, two cycles
// - Register loop repeats to PC plus offset register+1 times, two cycles
// - Distance op squares difference into accumulator, updates overflow, not saturate
`timescale 1ns/1ps
module cdl_exec
  import cdl_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire logic loop_end_hit,
  output logic irq_block,
  output logic issue_stall,
  output logic loop_active
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] working_reg;
    logic [15:0] opa_hi;
    logic [15:0] opb;
    logic [15:0] lit;
    logic [15:0] offset;
    logic [15:0] pc;
    cdl_op_t op;
    logic acc_sel;
    logic [15:0] quot;
    logic [15:0] rem;
    logic carry_flag;
    logic zero_flag;
    logic overflow_flag;
    logic neg_flag;
    logic digit_carry_flag;
    cdl_ex_t ex;
    logic [4:0] step;
    logic [15:0] prem;
    logic [15:0] pquo;
    logic [15:0] dmag;
    logic q_neg;
    logic r_neg;
    logic div_err;
    logic [13:0] hold_cnt;
    logic irq_block;
    logic loop_active;
    logic stall;
    logic [15:0] loop_cnt;
    logic [15:0] loop_end;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_saturate;
    logic acc_b_saturate;
  } cdl_st_t;

  cdl_st_t s;
  cdl_st_t next_s;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Operand decode for the divider
  logic signed_op;
  logic [31:0] dvd;
  logic [31:0] dvd_mag;
  logic [15:0] dvs_mag;
  logic [16:0] trial;
  logic [15:0] q_fix;
  logic [15:0] r_fix;
  logic q_big;
  logic [8:0] bcd_t;
  logic [16:0] diff;
  logic [33:0] sq;
  logic [7:0] wa;
  logic [7:0] ra;
  logic do_wr;
  logic start_req;
  cdl_op_t cur_op;
  logic cur_acc;
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    signed_op = (cur_op == OP_SDIV16) || (cur_op == OP_SDIV32) ||
                (cur_op == OP_FDIV);
    unique case (cur_op)
      OP_SDIV16: dvd = {{16{s.working_reg[15]}}, s.working_reg};
      OP_SDIV32, OP_UDIV32: dvd = {s.opa_hi, s.working_reg};
      OP_FDIV: dvd = {s.working_reg[15], s.working_reg, 15'h0000};
      default: dvd = {16'h0000, s.working_reg};
    endcase
    dvd_mag = (signed_op && dvd[31]) ? 32'(-dvd) : dvd;
    dvs_mag = (signed_op && s.opb[15]) ? 16'(-s.opb) : s.opb;
    trial = {s.prem, s.pquo[15]};
    q_big = signed_op && (s.pquo > 16'h7fff) &&
            !(s.q_neg && (s.pquo == 16'h8000));
    q_fix = s.q_neg ? 16'(-s.pquo) : s.pquo;
    r_fix = s.r_neg ? 16'(-s.prem) : s.prem;
    bcd_t = {1'b0, s.working_reg[7:0]};
    if ((bcd_t[3:0] > 4'h9) || s.digit_carry_flag) begin
      bcd_t = 9'(bcd_t + 9'h006);
    end
    if ((bcd_t[8:4] > 5'h09) || s.carry_flag) begin
      bcd_t = 9'(bcd_t + 9'h060);
    end
    diff = 17'({s.working_reg[15], s.working_reg} - {s.opb[15], s.opb});
    sq = 34'($signed(diff) * $signed(diff));
  end

  always_comb begin
    wa = s_axi_awaddr;
    ra = s_axi_araddr;
    do_wr = s_axi_awvalid && s_axi_wvalid && !s.awready && !s.bvalid;
    start_req = do_wr && (wa == CTRL_OFS) && s_axi_wstrb[0] &&
                s_axi_wdata[CTRL_START_BIT] && (s.ex == EX_IDLE);
    // Start runs the op written with it, not the one stored before
    cur_op = start_req ? cdl_op_t'(s_axi_wdata[CTRL_OP_LSB +: 4]) : s.op;
    cur_acc = start_req ? s_axi_wdata[CTRL_ACC_BIT] : s.acc_sel;
    rd_ok = 1'b1;
    unique case (ra)
      CTRL_OFS: rd_val = {26'h0, s.acc_sel, 1'b0, s.op};
      OPA_OFS: rd_val = {16'h0, s.working_reg};
      OPA_HI_OFS: rd_val = {16'h0, s.opa_hi};
      OPB_OFS: rd_val = {16'h0, s.opb};
      LIT_OFS: rd_val = {16'h0, s.lit};
      OFFSET_OFS: rd_val = {16'h0, s.offset};
      PC_OFS: rd_val = {16'h0, s.pc};
      QUOT_OFS: rd_val = {16'h0, s.quot};
      REM_OFS: rd_val = {16'h0, s.rem};
      FLAGS_OFS: rd_val = {27'h0, s.digit_carry_flag, s.neg_flag,
                           s.overflow_flag, s.zero_flag, s.carry_flag};
      STATUS_OFS: rd_val = {25'h0, s.acc_b_saturate, s.acc_a_saturate,
                            s.acc_b_overflow, s.acc_a_overflow,
                            s.loop_active, s.irq_block, s.ex != EX_IDLE};
      ACC_A_LO_OFS: rd_val = s.acc_a[31:0];
      ACC_A_HI_OFS: rd_val = {24'h0, s.acc_a[39:32]};
      ACC_B_LO_OFS: rd_val = s.acc_b[31:0];
      ACC_B_HI_OFS: rd_val = {24'h0, s.acc_b[39:32]};
      LOOP_CNT_OFS: rd_val = {16'h0, s.loop_cnt};
      LOOP_END_OFS: rd_val = {16'h0, s.loop_end};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    // Write channel: address and data are taken together
    next_s.awready = do_wr;
    next_s.wready = do_wr;
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (wa)
        CTRL_OFS: begin
          if (s_axi_wstrb[0] && (s.ex == EX_IDLE)) begin
            next_s.op = cdl_op_t'(s_axi_wdata[CTRL_OP_LSB +: 4]);
            next_s.acc_sel = s_axi_wdata[CTRL_ACC_BIT];
          end
        end
        OPA_OFS: next_s.working_reg = merge16(s.working_reg, s_axi_wdata,
                                              s_axi_wstrb);
        OPA_HI_OFS: next_s.opa_hi = merge16(s.opa_hi, s_axi_wdata,
                                            s_axi_wstrb);
        OPB_OFS: next_s.opb = merge16(s.opb, s_axi_wdata, s_axi_wstrb);
        LIT_OFS: next_s.lit = merge16(s.lit, s_axi_wdata, s_axi_wstrb);
        OFFSET_OFS: next_s.offset = merge16(s.offset, s_axi_wdata,
                                            s_axi_wstrb);
        PC_OFS: next_s.pc = merge16(s.pc, s_axi_wdata, s_axi_wstrb);
        FLAGS_OFS: begin
          if (s_axi_wstrb[0]) begin
            next_s.carry_flag = s_axi_wdata[FL_C];
            next_s.zero_flag = s_axi_wdata[FL_Z];
            next_s.overflow_flag = s_axi_wdata[FL_OV];
            next_s.neg_flag = s_axi_wdata[FL_N];
            next_s.digit_carry_flag = s_axi_wdata[FL_DC];
          end
        end
        QUOT_OFS, REM_OFS, STATUS_OFS, ACC_A_LO_OFS, ACC_A_HI_OFS,
        ACC_B_LO_OFS, ACC_B_HI_OFS, LOOP_CNT_OFS, LOOP_END_OFS: ;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    next_s.arready = s_axi_arvalid && !s.arready && !s.rvalid;
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.arready && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_val;
      next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Hold counter runs down one per cycle
    if (s.hold_cnt != 14'h0000) begin
      next_s.hold_cnt = 14'(s.hold_cnt - 14'h0001);
      next_s.irq_block = (s.hold_cnt != 14'h0001);
    end
    if (s.loop_active && loop_end_hit) begin
      if (s.loop_cnt == 16'h0000) begin
        next_s.loop_active = 1'b0;
      end else begin
        next_s.loop_cnt = 16'(s.loop_cnt - 16'h0001);
      end
    end
    // Execution sequencer; start while busy is dropped
    unique case (s.ex)
      EX_IDLE: begin
        if (start_req) begin
          next_s.step = 5'h00;
          unique case (cur_op)
            OP_BCD: begin
              next_s.working_reg = {s.working_reg[15:8], bcd_t[7:0]};
              next_s.carry_flag = bcd_t[8] | s.carry_flag;
            end
            OP_HOLD: begin
              next_s.hold_cnt = s.lit[13:0];
              next_s.irq_block = (s.lit[13:0] != 14'h0000);
            end
            OP_SDIV16, OP_SDIV32, OP_UDIV16, OP_UDIV32, OP_FDIV: begin
              if ((cur_op != OP_FDIV) || HAS_DSP) begin
                next_s.ex = EX_DIV;
                next_s.prem = dvd_mag[31:16];
                next_s.pquo = dvd_mag[15:0];
                next_s.dmag = dvs_mag;
                next_s.q_neg = signed_op && (dvd[31] ^ s.opb[15]);
                next_s.r_neg = signed_op && dvd[31];
                next_s.div_err = (dvs_mag == 16'h0000) ||
                                 (dvd_mag[31:16] >= dvs_mag);
              end
            end
            OP_LOOP_LIT, OP_LOOP_REG: next_s.ex = EX_LOOP;
            OP_DIST: begin
              if (cur_acc) begin
                next_s.acc_b = {6'h00, sq};
                next_s.acc_b_overflow = (sq[33:31] != 3'h0);
              end else begin
                next_s.acc_a = {6'h00, sq};
                next_s.acc_a_overflow = (sq[33:31] != 3'h0);
              end
            end
            default: ;
          endcase
        end
      end
      EX_DIV: begin
        next_s.step = 5'(s.step + 5'h01);
        if (s.step < 5'h10) begin
          // Restoring step: remainder stays below the divisor
          if (trial >= {1'b0, s.dmag}) begin
            next_s.prem = 16'(trial - {1'b0, s.dmag});
            next_s.pquo = {s.pquo[14:0], 1'b1};
          end else begin
            next_s.prem = trial[15:0];
            next_s.pquo = {s.pquo[14:0], 1'b0};
          end
        end else if (s.step == 5'h10) begin
          next_s.div_err = s.div_err | q_big;
          next_s.pquo = q_fix;
          next_s.prem = r_fix;
        end else if (s.step == DIV_LAST) begin
          next_s.quot = s.pquo;
          next_s.rem = s.prem;
          next_s.neg_flag = s.pquo[15];
          next_s.zero_flag = (s.pquo == 16'h0000);
          next_s.carry_flag = (s.prem != 16'h0000);
          next_s.overflow_flag = s.div_err;
          next_s.ex = EX_IDLE;
        end
      end
      EX_LOOP: begin
        next_s.step = 5'(s.step + 5'h01);
        if (s.step == 5'h00) begin
          next_s.loop_end = 16'(s.pc + s.offset);
        end else if (s.step == LOOP_LAST) begin
          next_s.loop_cnt = (s.op == OP_LOOP_LIT) ?
                            {1'b0, s.lit[14:0]} : s.working_reg;
          next_s.loop_active = 1'b1;
          next_s.ex = EX_IDLE;
        end
      end
      default: next_s.ex = EX_IDLE;
    endcase
    next_s.stall = (next_s.ex != EX_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ex <= EX_IDLE;
      s.op <= OP_BCD;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign irq_block = s.irq_block;
  assign issue_stall = s.stall;
  assign loop_active = s.loop_active;
endmodule

// ### inc/cdl_pkg.sv
// Constants and types for the divide, loop and DSP execution slice
package cdl_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OPA_OFS = 8'h04;
  localparam logic [7:0] OPA_HI_OFS = 8'h08;
  localparam logic [7:0] OPB_OFS = 8'h0c;
  localparam logic [7:0] LIT_OFS = 8'h10;
  localparam logic [7:0] OFFSET_OFS = 8'h14;
  localparam logic [7:0] PC_OFS = 8'h18;
  localparam logic [7:0] QUOT_OFS = 8'h1c;
  localparam logic [7:0] REM_OFS = 8'h20;
  localparam logic [7:0] FLAGS_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] ACC_A_LO_OFS = 8'h2c;
  localparam logic [7:0] ACC_A_HI_OFS = 8'h30;
  localparam logic [7:0] ACC_B_LO_OFS = 8'h34;
  localparam logic [7:0] ACC_B_HI_OFS = 8'h38;
  localparam logic [7:0] LOOP_CNT_OFS = 8'h3c;
  localparam logic [7:0] LOOP_END_OFS = 8'h40;
  // CTRL fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_ACC_BIT = 5;
  // FLAGS fields
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_OV = 2;
  localparam int FL_N = 3;
  localparam int FL_DC = 4;
  // STATUS fields
  localparam int ST_BUSY = 0;
  localparam int ST_IRQ = 1;
  localparam int ST_LOOP = 2;
  localparam int ST_OA = 3;
  localparam int ST_OB = 4;
  localparam int ST_SA = 5;
  localparam int ST_SB = 6;
  // Timing in instruction cycles
  localparam int DIV_CYCLES = 18;
  localparam int LOOP_CYCLES = 2;
  localparam logic [4:0] DIV_LAST = 5'(DIV_CYCLES - 1);
  localparam logic [4:0] LOOP_LAST = 5'(LOOP_CYCLES - 1);
  localparam logic HAS_DSP = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    OP_BCD = 4'h0, OP_HOLD = 4'h1, OP_SDIV16 = 4'h2, OP_SDIV32 = 4'h3,
    OP_UDIV16 = 4'h4, OP_UDIV32 = 4'h5, OP_FDIV = 4'h6, OP_LOOP_LIT = 4'h7,
    OP_LOOP_REG = 4'h8, OP_DIST = 4'h9
  } cdl_op_t;
  typedef enum logic [2:0] {
    EX_IDLE = 3'b001, EX_DIV = 3'b010, EX_LOOP = 3'b100
  } cdl_ex_t;
endpackage

// ### tb/cdl_exec_assertions.sv
// Concurrent checks on the execution slice ports
`timescale 1ns/1ps
module cdl_exec_chk
  import cdl_pkg::*;
(
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire logic irq_block,
  input wire logic issue_stall,
  input wire logic loop_active
);
  logic take;
  logic go;
  logic [3:0] op;
  logic [13:0] lit;
  assign take = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
    !s_axi_bvalid;
  assign go = take && s_axi_awaddr == CTRL_OFS && !issue_stall &&
    s_axi_wdata[CTRL_START_BIT] && s_axi_wstrb[0];
  assign op = s_axi_wdata[3:0];
  // Shadow of the hold count, so a zero count expects no block
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lit <= 14'h0;
    end else if (take && s_axi_awaddr == LIT_OFS) begin
      lit <= s_axi_wdata[13:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  div_stall_len_a: assert property (
    go && op >= 4'h2 && op <= 4'h6 |=> issue_stall[*8] ##1 issue_stall[*8]
      ##1 issue_stall[*2] ##1 !issue_stall)
    else $error("divide stall length wrong");
  loop_stall_len_a: assert property (
    go && (op == OP_LOOP_LIT || op == OP_LOOP_REG) |=> issue_stall[*2]
      ##1 !issue_stall)
    else $error("loop setup stall length wrong");
  loop_starts_a: assert property (
    go && (op == OP_LOOP_LIT || op == OP_LOOP_REG) |-> ##[1:3] loop_active)
    else $error("loop did not start");
  irq_hold_on_a: assert property (
    go && op == OP_HOLD && lit != 14'h0 |-> ##[1:2] irq_block)
    else $error("interrupt hold did not start");
  single_cycle_op_a: assert property (
    go && (op == OP_BCD || op == OP_HOLD || op == OP_DIST) |=> !issue_stall)
    else $error("single cycle op stalled issue");
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data ready differ");
  write_answer_a: assert property (take |=> s_axi_awready && s_axi_bvalid)
    else $error("write not answered next cycle");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

bind cdl_exec cdl_exec_chk u_cdl_exec_chk (
  .sys_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_block, .issue_stall,
  .loop_active
);

// ### tb/testbench.sv
// Self-checking bench for the execution slice
`timescale 1ns/1ps
module testbench
  import cdl_pkg::*;
;
  logic sys_clk, rst_n, ce, loop_end_hit;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq_block, issue_stall, loop_active;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_irq = 0;
  // Divide cases: ops, dividend, divisor, quotient, remainder, flags
  logic [3:0] dop [6] = '{OP_UDIV16, OP_UDIV16, OP_SDIV16, OP_SDIV32,
    OP_UDIV32, OP_FDIV};
  logic [31:0] da [6] = '{32'h64, 32'h3, 32'hff9c, 32'hfffeee90,
    32'h10000, 32'h2000};
  logic [15:0] db [6] = '{16'h7, 16'h7, 16'h7, 16'ha, 16'h2, 16'h4000};
  logic [15:0] eq [6] = '{16'he, 16'h0, 16'hfff2, 16'he4a8, 16'h8000,
    16'h4000};
  logic [15:0] er [6] = '{16'h2, 16'h3, 16'hfffe, 16'h0, 16'h0, 16'h0};
  logic [7:0] ef [6] = '{8'h1, 8'h3, 8'h9, 8'h8, 8'h8, 8'h0};

  cdl_exec u_cdl_exec (
    .sys_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .loop_end_hit, .irq_block, .issue_stall, .loop_active
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hold cycles are counted here since they start inside a bus write
  always @(posedge sys_clk) begin
    cyc++;
    if (irq_block === 1'b1) n_irq++;
    if (cyc == 6000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Ready is raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(r));
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
    input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(nm, s_axi_rdata, e);
    chk("rresp", 32'(s_axi_rresp), 32'(r));
  endtask

  task automatic idle();
    for (int k = 0; k < 40 && issue_stall !== 1'b0; k++) @(posedge sys_clk);
  endtask

  task automatic hit();
    @(posedge sys_clk);
    loop_end_hit <= 1'b1;
    @(posedge sys_clk);
    loop_end_hit <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, loop_end_hit} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("outputs", 32'({irq_block, issue_stall, loop_active}), 32'h0);
    rc("status", STATUS_OFS, 32'h0);
    wr(8'hfc, 32'h0, RESP_SLVERR);
    rc("unmapped", 8'hfc, 32'h0, RESP_SLVERR);
    wr(STATUS_OFS, 32'h7f);
    rc("status_ro", STATUS_OFS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(OPA_OFS, 32'(da[i][15:0]));
      wr(OPA_HI_OFS, 32'(da[i][31:16]));
      wr(OPB_OFS, 32'(db[i]));
      wr(CTRL_OFS, {27'h0, 1'b1, dop[i]});
      if (i == 0) begin
        rc("busy", STATUS_OFS, 32'h1);
        wr(CTRL_OFS, {27'h0, 1'b1, OP_SDIV16});
      end
      idle();
      rc("quot", QUOT_OFS, 32'(eq[i]));
      rc("rem", REM_OFS, 32'(er[i]));
      rc("flags", FLAGS_OFS, 32'(ef[i]));
    end
    wr(FLAGS_OFS, 32'h10);
    wr(OPA_OFS, 32'h61);
    wr(CTRL_OFS, 32'h10);
    rc("bcd", OPA_OFS, 32'h67);
    rc("bcd_flags", FLAGS_OFS, 32'h10);
    wr(FLAGS_OFS, 32'h0);
    wr(OPA_OFS, 32'h9a);
    wr(CTRL_OFS, 32'h10);
    rc("bcd", OPA_OFS, 32'h0);
    rc("bcd_flags", FLAGS_OFS, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(LIT_OFS, 32'(5 >> (2 * i)));
      n_irq = 0;
      wr(CTRL_OFS, 32'h11);
      repeat (12) @(posedge sys_clk);
      chk("hold_len", 32'(n_irq), 32'(5 >> (2 * i)));
    end
    rc("hold_flags", FLAGS_OFS, 32'h1);
    wr(LIT_OFS, 32'h2);
    wr(OPA_OFS, 32'h1);
    wr(OFFSET_OFS, 32'h10);
    wr(PC_OFS, 32'h100);
    for (int i = 0; i < 2; i++) begin
      wr(CTRL_OFS, 32'h17 + 32'(i));
      idle();
      rc("loop_end", LOOP_END_OFS, 32'h110);
      rc("loop_cnt", LOOP_CNT_OFS, 32'(2 - i));
      for (int h = 0; h < 3 - i; h++) begin
        chk("loop_on", 32'(loop_active), 32'h1);
        hit();
      end
      chk("loop_off", 32'(loop_active), 32'h0);
    end
    wr(OPA_OFS, 32'ha);
    wr(OPB_OFS, 32'h3);
    wr(CTRL_OFS, 32'h19);
    wr(CTRL_OFS, 32'h39);
    rc("acc_a", ACC_A_LO_OFS, 32'h31);
    rc("acc_a_hi", ACC_A_HI_OFS, 32'h0);
    rc("acc_b", ACC_B_LO_OFS, 32'h31);
    rc("dist_status", STATUS_OFS, 32'h0);
    end_of_test();
  end
endmodule
